/* inc/fifo_cfg_pkg.sv */
// Package: constants for the configurable FIFO flag and configuration block
package fifo_cfg_pkg;
  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int DATA_W  = 18;
  localparam int BYTE_W  = 9;
  localparam int DEPTH   = 16;
  localparam int PTR_W   = 5;           // One extra wrap bit
  localparam int ADDR_W  = 4;
  localparam int OFS_W   = 4;
  localparam logic [PTR_W-1:0] CAP_WORDS = 5'h10;
  localparam logic [PTR_W-1:0] HALF_WORDS = 5'h08;
  localparam logic [PTR_W-1:0] PTR_RST   = 5'h00;
  localparam logic [DATA_W-1:0] DOUT_RST = 18'h00000;
  // ----------------------------------------------------------------
  // Default offset table, index {sel1, sel0, load}
  // ----------------------------------------------------------------
  localparam logic [OFS_W-1:0] DEF_OFS_0 = 4'h1;
  localparam logic [OFS_W-1:0] DEF_OFS_1 = 4'h2;
  localparam logic [OFS_W-1:0] DEF_OFS_2 = 4'h3;
  localparam logic [OFS_W-1:0] DEF_OFS_3 = 4'h4;
  localparam logic [OFS_W-1:0] DEF_OFS_4 = 4'h5;
  localparam logic [OFS_W-1:0] DEF_OFS_5 = 4'h6;
  localparam logic [OFS_W-1:0] DEF_OFS_6 = 4'h7;
  localparam logic [OFS_W-1:0] DEF_OFS_7 = 4'h8;
  // ----------------------------------------------------------------
  // AHB-Lite register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] CFG_OFS    = 8'h00;  // Latched configuration, read only
  localparam logic [7:0] STATUS_OFS = 8'h04;  // Flags and level, read only
  localparam logic [7:0] OFFS_OFS   = 8'h08;  // Empty/full offsets, read only
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ    = 2'h3;
  // Config bit positions
  localparam int CFG_BYTE_ORDER = 0;
  localparam int CFG_WIDTH9     = 1;
  localparam int CFG_FIRST_WORD_FALL_THROUGH       = 2;
  localparam int CFG_PARITY     = 3;
  localparam int CFG_SERIAL     = 4;
  // Programming state machine
  typedef enum logic [2:0] {
    ST_RESET = 3'b001,
    ST_RUN   = 3'b010,
    ST_HOLD  = 3'b100
  } run_state_e;
endpackage

/* rtl/fifo_cfg_flags.sv */
// FIFO core with reset-latched configuration, flags and offset programming
`timescale 1ns/1ns
module fifo_cfg_flags
  import fifo_cfg_pkg::*;
(
  input  wire logic                          clock,
  input  wire logic                          rst_n,
  input  wire logic                          clk_en,
  input  wire logic                          master_reset_n,
  input  wire logic                          byte_order_select,
  input  wire logic                          write_width_select,
  input  wire logic                          parity_placement_select,
  input  wire logic                          default_offset_select0,
  input  wire logic                          default_offset_select1,
  input  wire logic                          fall_through_mode_serial_in,
  input  wire logic                          offset_load_n,
  input  wire logic                          serial_load_enable_n,
  input  wire logic                          write_enable_n,
  input  wire logic                          read_enable_n,
  input  wire logic [fifo_cfg_pkg::DATA_W-1:0] write_data_in,
  output logic [fifo_cfg_pkg::DATA_W-1:0]    read_data_out,
  output logic                               empty_or_output_ready_n,
  output logic                               full_or_input_ready_n,
  output logic                               half_full_flag_n,
  output logic                               almost_empty_flag_n,
  output logic                               almost_full_flag_n,
  input  wire logic                          hsel,
  input  wire logic [31:0]                   haddr,
  input  wire logic [1:0]                    htrans,
  input  wire logic                          hwrite,
  input  wire logic [2:0]                    hsize,
  input  wire logic [31:0]                   hwdata,
  input  wire logic                          hready,
  output logic [31:0]                        hrdata,
  output logic                               hreadyout,
  output logic                               hresp
);
  import fifo_cfg_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] mem_reg [DEPTH];
  logic [PTR_W-1:0]  wptr_reg;
  logic [PTR_W-1:0]  rptr_reg;
  logic              out_valid_reg;
  logic [OFS_W-1:0]  empty_ofs_reg;
  logic [OFS_W-1:0]  full_ofs_reg;
  logic [OFS_W-1:0]  empty_ofs_next;
  logic [OFS_W-1:0]  full_ofs_next;
  logic              ofs_sel_reg;       // 0 loads empty offset, 1 full offset
  logic [2*OFS_W-1:0] ser_shift_reg;
  logic [3:0]        ser_cnt_reg;
  logic              serial_mode_reg;
  logic [2:0]        def_idx_reg;
  run_state_e        state_reg;
  logic              read_sel_reg;
  logic [7:0]        read_addr_reg;
  logic              big_endian;
  logic              width9;
  logic              first_word_fall_through;
  logic              parity_inter;
  logic              in_reset;

  // ----------------------------------------------------------------
  // Strap latches
  // ----------------------------------------------------------------
  assign in_reset = !master_reset_n;

  // Byte order kept as pin level, so high means big-endian
  fifo_cfg_latch u_byte_order (
    .clock     (clock),
    .rst_n     (rst_n),
    .clk_en    (clk_en),
    .capture   (in_reset),
    .strap_in  (byte_order_select),
    .strap_out (big_endian)
  );
  fifo_cfg_latch u_width (
    .clock     (clock),
    .rst_n     (rst_n),
    .clk_en    (clk_en),
    .capture   (in_reset),
    .strap_in  (write_width_select),
    .strap_out (width9)
  );
  fifo_cfg_latch u_first_word_fall_through (
    .clock     (clock),
    .rst_n     (rst_n),
    .clk_en    (clk_en),
    .capture   (in_reset),
    .strap_in  (fall_through_mode_serial_in),
    .strap_out (first_word_fall_through)
  );
  fifo_cfg_latch u_parity (
    .clock     (clock),
    .rst_n     (rst_n),
    .clk_en    (clk_en),
    .capture   (in_reset),
    .strap_in  (parity_placement_select),
    .strap_out (parity_inter)
  );

  // ----------------------------------------------------------------
  // Decode of the offset-load pin and the data path
  // ----------------------------------------------------------------
  // Pins are trusted stable once reset ends, so no re-checking
  wire               running    = (state_reg == ST_RUN);
  wire               ofs_access = running && !offset_load_n;
  wire [PTR_W-1:0]   level      = wptr_reg - rptr_reg;
  wire               mem_full   = (level == CAP_WORDS);
  wire               mem_empty  = (level == PTR_RST);
  wire               data_wr    = running && offset_load_n && !write_enable_n && !mem_full;
  wire               data_rd    = running && offset_load_n && !read_enable_n;
  wire [DATA_W-1:0]  wr_word    = width9 ? {9'h000, write_data_in[BYTE_W-1:0]}
                                         : write_data_in;
  // Fall-through keeps one word in the output stage, so the loading is
  // separate from the reading request
  wire               out_load   = !mem_empty && (first_word_fall_through ? (!out_valid_reg || data_rd) : data_rd);
  wire               ser_load   = ofs_access && serial_mode_reg && !serial_load_enable_n;
  wire               par_load   = ofs_access && !serial_mode_reg && !write_enable_n;
  // Interspersed parity in 18-bit width drops bit 8; otherwise bits 16 and 17 are unused
  wire [15:0]        par_bits   = (!width9 && parity_inter) ? {write_data_in[16:9], write_data_in[7:0]}
                                                            : write_data_in[15:0];
  wire [2*OFS_W-1:0] ser_word   = {ser_shift_reg[2*OFS_W-2:0], fall_through_mode_serial_in};
  wire [OFS_W-1:0]   def_ofs    = (def_idx_reg == 3'h0) ? DEF_OFS_0 :
                                  (def_idx_reg == 3'h1) ? DEF_OFS_1 :
                                  (def_idx_reg == 3'h2) ? DEF_OFS_2 :
                                  (def_idx_reg == 3'h3) ? DEF_OFS_3 :
                                  (def_idx_reg == 3'h4) ? DEF_OFS_4 :
                                  (def_idx_reg == 3'h5) ? DEF_OFS_5 :
                                  (def_idx_reg == 3'h6) ? DEF_OFS_6 : DEF_OFS_7;
  wire [DATA_W-1:0]  mem_word   = mem_reg[rptr_reg[ADDR_W-1:0]];

  // Offset register next values: default, parallel or serial load
  always_comb begin
    empty_ofs_next = empty_ofs_reg;
    full_ofs_next  = full_ofs_reg;
    if (state_reg == ST_HOLD) begin
      empty_ofs_next = def_ofs;
      full_ofs_next  = def_ofs;
    end else if (par_load) begin
      if (ofs_sel_reg) begin
        full_ofs_next = par_bits[OFS_W-1:0];
      end else begin
        empty_ofs_next = par_bits[OFS_W-1:0];
      end
    end else if (ser_load && (ser_cnt_reg == 4'h7)) begin
      empty_ofs_next = ser_word[2*OFS_W-1:OFS_W];
      full_ofs_next  = ser_word[OFS_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Reset sequencing: straps captured while held, defaults on release
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_RESET;
    end else if (clk_en) begin
      unique case (state_reg)
        ST_RESET: begin
          if (!in_reset) begin
            state_reg <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          state_reg <= ST_RUN;
        end
        ST_RUN: begin
          if (in_reset) begin
            state_reg <= ST_RESET;
          end
        end
      endcase
    end
  end

  // Load pin and selects form the default index and programming method
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      def_idx_reg     <= 3'h0;
      serial_mode_reg <= 1'b0;
    end else if (clk_en && in_reset) begin
      def_idx_reg     <= {default_offset_select1, default_offset_select0, offset_load_n};
      serial_mode_reg <= offset_load_n;
    end
  end

  // ----------------------------------------------------------------
  // Offset registers and serial shifter
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      empty_ofs_reg <= 4'h0;
      full_ofs_reg  <= 4'h0;
      ofs_sel_reg   <= 1'b0;
      ser_shift_reg <= 8'h00;
      ser_cnt_reg   <= 4'h0;
    end else if (clk_en) begin
      empty_ofs_reg <= empty_ofs_next;
      full_ofs_reg  <= full_ofs_next;
      if (in_reset) begin
        ofs_sel_reg <= 1'b0;
        ser_cnt_reg <= 4'h0;
      end else begin
        if (par_load) begin
          ofs_sel_reg <= !ofs_sel_reg;  // Empty then full, then wraps
        end
        if (ser_load) begin
          ser_shift_reg <= ser_word;
          ser_cnt_reg   <= (ser_cnt_reg == 4'h7) ? 4'h0 : ser_cnt_reg + 4'h1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Storage and pointers
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (clk_en && data_wr) begin
      mem_reg[wptr_reg[ADDR_W-1:0]] <= wr_word;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wptr_reg      <= PTR_RST;
      rptr_reg      <= PTR_RST;
      read_data_out <= DOUT_RST;
      out_valid_reg <= 1'b0;
    end else if (clk_en) begin
      if (in_reset) begin
        wptr_reg      <= PTR_RST;
        rptr_reg      <= PTR_RST;
        read_data_out <= DOUT_RST;
        out_valid_reg <= 1'b0;
      end else begin
        if (data_wr) begin
          wptr_reg <= wptr_reg + 5'h01;
        end
        if (out_load) begin
          rptr_reg      <= rptr_reg + 5'h01;
          read_data_out <= mem_word;
          out_valid_reg <= 1'b1;
        end else if (data_rd && first_word_fall_through) begin
          out_valid_reg <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Flags, registered and active low
  // ----------------------------------------------------------------
  // Flags see the next pointers' cause one edge later; simpler than lookahead
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      empty_or_output_ready_n <= 1'b0;
      full_or_input_ready_n   <= 1'b1;
      half_full_flag_n        <= 1'b1;
      almost_empty_flag_n     <= 1'b0;
      almost_full_flag_n      <= 1'b1;
    end else if (clk_en) begin
      empty_or_output_ready_n <= first_word_fall_through ? !out_valid_reg : !mem_empty;
      full_or_input_ready_n   <= first_word_fall_through ? mem_full : !mem_full;
      half_full_flag_n        <= !(level > HALF_WORDS);
      almost_empty_flag_n     <= !(level < {1'b0, empty_ofs_reg});
      almost_full_flag_n      <= !((CAP_WORDS - level) <= {1'b0, full_ofs_reg});
    end
  end

  // ----------------------------------------------------------------
  // AHB-Lite slave: zero wait state, read only, always OKAY
  // ----------------------------------------------------------------
  wire        ahb_take = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
  wire [31:0] cfg_word = {27'h0000000, serial_mode_reg, parity_inter, first_word_fall_through, width9, big_endian};
  wire [31:0] sta_word = {22'h000000, level, empty_or_output_ready_n, full_or_input_ready_n,
                          half_full_flag_n, almost_empty_flag_n, almost_full_flag_n};
  wire [31:0] ofs_word = {24'h000000, full_ofs_reg, empty_ofs_reg};
  wire [31:0] rd_word  = (read_addr_reg == CFG_OFS)    ? cfg_word :
                         (read_addr_reg == STATUS_OFS) ? sta_word :
                         (read_addr_reg == OFFS_OFS)   ? ofs_word : 32'h00000000;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      read_sel_reg  <= 1'b0;
      read_addr_reg <= 8'h00;
      hrdata        <= 32'h00000000;
      hreadyout     <= 1'b1;
      hresp         <= 1'b0;
    end else if (clk_en) begin
      read_sel_reg  <= ahb_take && !hwrite;
      read_addr_reg <= haddr[7:0];
      hrdata        <= ahb_take && !hwrite ? ((haddr[7:0] == CFG_OFS) ? cfg_word :
                                              (haddr[7:0] == STATUS_OFS) ? sta_word :
                                              (haddr[7:0] == OFFS_OFS) ? ofs_word : 32'h00000000)
                                           : (read_sel_reg ? rd_word : 32'h00000000);
    end
  end
endmodule

/* rtl/fifo_cfg_latch.sv */
// Configuration strap latch captured while master reset is held
`timescale 1ns/1ns
module fifo_cfg_latch (
  input  wire logic                 clock,
  input  wire logic                 rst_n,
  input  wire logic                 clk_en,
  input  wire logic                 capture,
  input  wire logic                 strap_in,
  output logic                      strap_out
);
  // ----------------------------------------------------------------
  // Strap flop
  // ----------------------------------------------------------------
  // Reset takes a constant; the pin level is taken by the clock
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      strap_out <= 1'b0;
    end else if (clk_en && capture) begin
      strap_out <= strap_in;
    end
  end
endmodule

/* verif/data_port_model.sv */
// Producer and consumer model for the write and read data ports
`timescale 1ns/1ns
module data_port_model
  import fifo_cfg_pkg::*;
(
  input  wire logic                            clock,
  input  wire logic                            push,
  input  wire logic                            pop,
  input  wire logic                            narrow,
  input  wire logic                            slow,
  input  wire logic [fifo_cfg_pkg::DATA_W-1:0] push_data,
  output logic                                 write_enable_n,
  output logic                                 read_enable_n,
  output logic [fifo_cfg_pkg::DATA_W-1:0]      write_data_in
);
  logic                    phase_reg;
  // Idle data is flipped so a stale word never looks valid
  wire [DATA_W-1:0] next_word = push ? push_data : ~write_data_in;
  initial begin
    phase_reg = 1'b0;
    write_enable_n = 1'b1;
    read_enable_n = 1'b1;
    write_data_in = 18'h00000;
  end
  // Slow mode offers a word only every other cycle
  always @(posedge clock) begin
    phase_reg <= ~phase_reg;
    write_enable_n <= !(push && (!slow || phase_reg));
    read_enable_n <= !pop;
    write_data_in <= narrow ? {9'h000, next_word[8:0]} : next_word;
  end
endmodule

/* verif/fifo_cfg_flags_sva.sv */
// Checker: strap latching, flag levels and bus replies of the FIFO block
`timescale 1ns/1ns
module fifo_cfg_flags_chk
  import fifo_cfg_pkg::*;
(
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic        clk_en,
  input wire logic        master_reset_n,
  input wire logic        byte_order_select,
  input wire logic        write_width_select,
  input wire logic        parity_placement_select,
  input wire logic        default_offset_select0,
  input wire logic        default_offset_select1,
  input wire logic        fall_through_mode_serial_in,
  input wire logic        offset_load_n,
  input wire logic        serial_load_enable_n,
  input wire logic        write_enable_n,
  input wire logic        read_enable_n,
  input wire logic        empty_or_output_ready_n,
  input wire logic        full_or_input_ready_n,
  input wire logic        half_full_flag_n,
  input wire logic        almost_full_flag_n,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata
);
  logic [4:0]       cfg_reg;
  logic [2:0]       idx_reg;
  logic [1:0]       age_reg;
  logic [2:0]       quiet_reg;
  logic             prog_reg;
  logic [OFS_W-1:0] def_tab [8];
  // Status is only trusted once the data strobes have rested long enough
  wire rd_take = hsel && hready && htrans[1] && !hwrite;
  wire stat_q  = rd_take && haddr[7:0] == STATUS_OFS && quiet_reg == 3'h7 && age_reg == 2'h3;
  assign def_tab = '{DEF_OFS_0, DEF_OFS_1, DEF_OFS_2, DEF_OFS_3, DEF_OFS_4, DEF_OFS_5, DEF_OFS_6, DEF_OFS_7};
  // Shadow of the straps, time since master reset and strobe rest
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cfg_reg   <= 5'h00;
      idx_reg   <= 3'h0;
      age_reg   <= 2'h0;
      prog_reg  <= 1'b0;
      quiet_reg <= 3'h0;
    end else if (clk_en) begin
      quiet_reg <= (write_enable_n && read_enable_n) ? quiet_reg + {2'h0, quiet_reg != 3'h7} : 3'h0;
      if (!master_reset_n) begin
        cfg_reg  <= {offset_load_n, parity_placement_select, fall_through_mode_serial_in,
                     write_width_select, byte_order_select};
        idx_reg  <= {default_offset_select1, default_offset_select0, offset_load_n};
        age_reg  <= 2'h0;
        prog_reg <= 1'b0;
      end else begin
        age_reg  <= age_reg + {1'b0, age_reg != 2'h3};
        prog_reg <= prog_reg | (!offset_load_n && (!write_enable_n || !serial_load_enable_n));
      end
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  cfg_read_a: assert property (
    rd_take && haddr[7:0] == CFG_OFS && age_reg == 2'h3 |=> hrdata[4:0] == cfg_reg)
    else $error("configuration bits differ from straps");
  def_offs_a: assert property (
    rd_take && haddr[7:0] == OFFS_OFS && age_reg == 2'h3 && !prog_reg |=> hrdata[7:0] == {2{def_tab[idx_reg]}})
    else $error("default offsets differ from select table");
  mrst_flags_a: assert property (
    clk_en && !master_reset_n ##1 clk_en && !master_reset_n |=> half_full_flag_n && almost_full_flag_n)
    else $error("flags not idle after master reset");
  empty_std_a: assert property (
    stat_q && !cfg_reg[2] |=> empty_or_output_ready_n == (hrdata[9:5] != 5'h00))
    else $error("empty flag disagrees with level");
  full_ir_a: assert property (
    stat_q |=> full_or_input_ready_n == ((hrdata[9:5] == CAP_WORDS) == cfg_reg[2]))
    else $error("full or input ready disagrees with level");
  half_full_a: assert property (
    stat_q |=> half_full_flag_n == (hrdata[9:5] <= HALF_WORDS))
    else $error("half full flag disagrees with level");
  level_cap_a: assert property (
    rd_take && haddr[7:0] == STATUS_OFS |=> hrdata[9:5] <= CAP_WORDS)
    else $error("level above capacity");
  unmapped_a: assert property (
    rd_take && haddr[7:0] > OFFS_OFS |=> hrdata == 32'h00000000)
    else $error("unmapped read not zero");
endmodule
bind fifo_cfg_flags fifo_cfg_flags_chk chk (.clock, .rst_n, .clk_en, .master_reset_n, .byte_order_select,
  .write_width_select, .parity_placement_select, .default_offset_select0, .default_offset_select1,
  .fall_through_mode_serial_in, .offset_load_n, .serial_load_enable_n, .write_enable_n, .read_enable_n,
  .empty_or_output_ready_n, .full_or_input_ready_n, .half_full_flag_n, .almost_full_flag_n, .hsel,
  .haddr, .htrans, .hwrite, .hready, .hrdata);

/* verif/fifo_cfg_flags_tb.sv */
// Testbench for the FIFO configuration and flag block
`timescale 1ns/1ns
module fifo_cfg_flags_tb;
  import fifo_cfg_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic              clock = 1'b0, rst_n = 1'b0, clk_en = 1'b1, master_reset_n = 1'b0;
  logic              byte_order_select = 1'b0, write_width_select = 1'b0, parity_placement_select = 1'b0;
  logic              default_offset_select0 = 1'b0, default_offset_select1 = 1'b0;
  logic              fall_through_mode_serial_in = 1'b0, offset_load_n = 1'b1, serial_load_enable_n = 1'b1;
  logic              push = 1'b0, pop = 1'b0, slow = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [DATA_W-1:0] push_data = 18'h00000;
  logic [31:0]       haddr = 32'h0, hwdata = 32'h0;
  logic [1:0]        htrans = 2'h0;
  logic [2:0]        hsize = 3'h2;
  logic              write_enable_n, read_enable_n, hready, hreadyout, hresp;
  logic [DATA_W-1:0] write_data_in, read_data_out;
  logic [31:0]       hrdata;
  logic              empty_or_output_ready_n, full_or_input_ready_n, half_full_flag_n;
  logic              almost_empty_flag_n, almost_full_flag_n;
  int                n_fail = 0, n_tests = 0, cyc = 0;
  logic [OFS_W-1:0]  defs [8] = '{DEF_OFS_0, DEF_OFS_1, DEF_OFS_2, DEF_OFS_3, DEF_OFS_4, DEF_OFS_5, DEF_OFS_6, DEF_OFS_7};
  assign hready = hreadyout;
  fifo_cfg_flags dut (.clock, .rst_n, .clk_en, .master_reset_n, .byte_order_select, .write_width_select,
    .parity_placement_select, .default_offset_select0, .default_offset_select1, .fall_through_mode_serial_in,
    .offset_load_n, .serial_load_enable_n, .write_enable_n, .read_enable_n, .write_data_in, .read_data_out,
    .empty_or_output_ready_n, .full_or_input_ready_n, .half_full_flag_n, .almost_empty_flag_n,
    .almost_full_flag_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp);
  data_port_model partner (.clock, .push, .pop, .narrow(write_width_select), .slow, .push_data,
    .write_enable_n, .read_enable_n, .write_data_in);
  // Clock, and a hang guard well above the run length
  always #5 clock = ~clock;
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      results;
    end
  end
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One single AHB-Lite transfer; waits on hready in both phases
  task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clock);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    hwrite <= w;
    htrans <= HTRANS_NONSEQ;
    do @(posedge clock); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    do @(posedge clock); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  // Straps {load, sel1, sel0, fall through, parity, width, byte order}
  task automatic mreset(input logic [6:0] st);
    @(posedge clock);
    master_reset_n <= 1'b0;
    {offset_load_n, default_offset_select1, default_offset_select0, fall_through_mode_serial_in,
     parity_placement_select, write_width_select, byte_order_select} <= st;
    repeat (2) @(posedge clock);
    master_reset_n <= 1'b1; // straps other than load stay put
    offset_load_n <= 1'b1;
    repeat (4) @(posedge clock);
  endtask
  // Offers n words d, d+1, ... then lets the flags settle
  task automatic put(input int n, input logic [DATA_W-1:0] d);
    @(posedge clock);
    push <= 1'b1;
    for (int i = 0; i < n; i++) begin
      push_data <= d + DATA_W'(i);
      @(posedge clock);
    end
    push <= 1'b0;
    repeat (8) @(posedge clock);
  endtask
  task automatic take(input int n);
    @(posedge clock);
    pop <= 1'b1;
    repeat (n) @(posedge clock);
    pop <= 1'b0;
    repeat (8) @(posedge clock);
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_straps;
    logic [31:0] r;
    logic [6:0]  st;
    for (int i = 0; i < 8; i++) begin
      st = {i[0], i[2], i[1], i[1] ^ i[0], i[1], i[2], ~i[0]};
      mreset(st);
      ahb(CFG_OFS, 1'b0, 32'h0, r);
      check("config", r[4:0], {st[6], st[2], st[3], st[1:0]});
      ahb(OFFS_OFS, 1'b0, 32'h0, r);
      check("default offsets", r[7:0], {defs[i], defs[i]});
    end
    ahb(CFG_OFS, 1'b1, 32'h0000001F, r);
    ahb(CFG_OFS, 1'b0, 32'h0, r);
    check("config after write", r[4:0], 5'h1A);
    ahb(8'h0C, 1'b0, 32'h0, r);
    check("unmapped read", r, 32'h0);
    $display("test straps done");
  endtask
  task automatic t_std;
    logic [31:0] r;
    mreset(7'h44);
    check("empty at start", empty_or_output_ready_n, 1'b0);
    check("full at start", full_or_input_ready_n, 1'b1);
    put(17, 18'h2A5C3);
    ahb(STATUS_OFS, 1'b0, 32'h0, r);
    check("level full", r[9:5], CAP_WORDS);
    check("full flag", full_or_input_ready_n, 1'b0);
    check("half full flag", half_full_flag_n, 1'b0);
    take(1);
    check("first word", read_data_out, 18'h2A5C3);
    take(16);
    check("last word", read_data_out, 18'h2A5D2);
    check("empty again", empty_or_output_ready_n, 1'b0);
    check("half full idle", half_full_flag_n, 1'b1);
    $display("test standard done");
  endtask
  task automatic t_first_word_fall_through;
    logic [31:0] r;
    mreset(7'h4A);
    check("output cleared", read_data_out, DOUT_RST);
    check("no word ready", empty_or_output_ready_n, 1'b1);
    check("input ready", full_or_input_ready_n, 1'b0);
    put(1, 18'h3FF5A);
    check("fall through word", read_data_out, 18'h0015A);
    check("word ready", empty_or_output_ready_n, 1'b0);
    ahb(STATUS_OFS, 1'b0, 32'h0, r);
    check("level", r[9:5], 5'h00);
    $display("test fall through done");
  endtask
  task automatic t_offs;
    logic [31:0] r;
    mreset(7'h00);
    offset_load_n <= 1'b0;
    put(1, 18'h00005);
    put(1, 18'h0000C);
    offset_load_n <= 1'b1;
    ahb(OFFS_OFS, 1'b0, 32'h0, r);
    check("parallel offsets", r[7:0], 8'hC5);
    slow <= 1'b1;
    put(8, 18'h00100);
    slow <= 1'b0;
    check("almost empty", almost_empty_flag_n, 1'b0);
    put(1, 18'h00200);
    check("almost empty off", almost_empty_flag_n, 1'b1);
    check("almost full", almost_full_flag_n, 1'b0);
    mreset(7'h40);
    offset_load_n <= 1'b0;
    for (int b = 7; b >= 0; b--) begin
      @(posedge clock);
      serial_load_enable_n <= 1'b0;
      fall_through_mode_serial_in <= b[0] ^ (b == 7); // Bits 0010_1010, first bit leads
    end
    @(posedge clock);
    serial_load_enable_n <= 1'b1;
    put(1, 18'h00007);
    offset_load_n <= 1'b1;
    ahb(OFFS_OFS, 1'b0, 32'h0, r);
    check("serial offsets", r[7:0], 8'hA2);
    $display("test offsets done");
  endtask
  task automatic results;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    t_straps;
    t_std;
    t_first_word_fall_through;
    t_offs;
    results;
  end
endmodule
